/* File: verilog/pss_sequencer.sv */
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
// Behaviour
// - new step: 0V, 0A, 0.1s, volt, normal, on
// - re-added step returns its old values
// - no setting on steps not yet added
// - execute runs from step 0, halts after last
// - each step held for its dwell time, a dwell of 0 for 0.1s
// - cycle flag wraps last step to step 0
// - cancel halts, keeps current step output
// - reset halts, zeroes setpoints, disconnects output only when REVERSIBLE
// - execute from edit or stop restarts from step 0
// - remove step moves pointer to previous step
// - step 0 removable only when alone
// - removed step 0 keeps its values
// - every edit written to storage at once
// - polarity toggles; output on/off set enable
// - cancel while editing leaves program mode
// - leave program mode only from edit or stop
// - fixed-polarity reset stop gives keypad idle
// - stop restores the pre-run screen index
// - ten programs, 99 steps, 90 per program
module pss_sequencer
	import pss_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES,
	parameter bit REVERSIBLE    = 1'b1
)
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// axi4-lite read
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// regulator setpoints and panel state
	output pss_out_t         setpoint,
	output logic             program_mode,
	output logic             run_active,
	output logic             keypad_idle
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [9:0] mem_idx(logic [3:0] p, logic [6:0] s);
		return 10'(int'(p) * MAX_STEPS + int'(s));
	endfunction

	function automatic pss_out_t load_out(pss_step_t r);
		pss_out_t o;
		o = '{r.volt, r.curr, r.mode_curr, r.pol_rev, r.out_en};
		if (!REVERSIBLE)
		begin
			o.mode_curr = 1'b0;
			o.pol_rev   = 1'b0;
			o.out_en    = 1'b1;
		end
		return o;
	endfunction

	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d,
		logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	pss_step_t             mem [MEM_DEPTH];
	logic [MEM_DEPTH-1:0]  written_reg, written_next;
	logic [6:0]            count_reg [NUM_PROGS];
	logic [6:0]            count_next [NUM_PROGS];
	logic [NUM_PROGS-1:0]  cycle_reg, cycle_next;
	pss_state_t            state_reg, state_next;
	logic [3:0]            prog_reg, prog_next;
	logic [6:0]            step_reg, step_next;
	logic [6:0]            run_step_reg, run_step_next;
	logic [6:0]            total_reg, total_next;
	logic [2:0]            screen_reg, screen_next;
	logic [2:0]            saved_reg, saved_next;
	logic [15:0]           value_reg, value_next;
	pss_out_t              out_reg, out_next;
	logic                  by_reset_reg, by_reset_next;
	logic                  refused_reg, refused_next;
	logic                  keypad_reg, keypad_next;
	logic                  aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [7:0]            awaddr_reg, awaddr_next;
	logic [31:0]           wdata_reg, wdata_next;
	logic [3:0]            wstrb_reg, wstrb_next;
	logic                  awready_reg, awready_next, wready_reg, wready_next;
	logic                  bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic                  rvalid_reg, rvalid_next;
	logic [1:0]            bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0]           rdata_reg, rdata_next;

	logic                  wr_fire, timer_start, timer_done, mem_we, edit_ok;
	logic                  last_step;
	logic [9:0]            mem_wa, new_idx;
	pss_step_t             mem_wd, edit_rec, run_rec;
	pss_cmd_t              cmd;
	logic [6:0]            cur_count, nxt_step;
	pss_status_t           status;
	pss_count_t            cnt_view;

	assign cur_count = count_reg[prog_reg];
	assign nxt_step  = 7'(run_step_reg + 7'h01);
	assign last_step = nxt_step >= cur_count;
	assign new_idx   = mem_idx(prog_reg, cur_count);
	assign edit_rec  = mem[mem_idx(prog_reg, step_reg)];
	assign run_rec   = mem[mem_idx(prog_reg,
		(state_reg != ST_RUN || last_step) ? 7'h00 : nxt_step)];
	assign edit_ok   = state_reg == ST_EDIT && step_reg < cur_count;
	assign wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;
	assign status    = '{5'h00, run_step_reg, step_reg, prog_reg, screen_reg,
		refused_reg, by_reset_reg, keypad_reg, cycle_reg[prog_reg], state_reg};
	assign cnt_view  = '{17'h00000, total_reg, 1'b0, cur_count};

	pss_dwell_timer #(
		.TICK_P (TICK_CYCLES_P)
	) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (timer_start),
		.dwell   (run_rec.dwell),
		.done    (timer_done)
	);

	// ****************************************************************
	// next-state logic: bus slave, commands, execution
	// ****************************************************************
	always_comb
	begin
		written_next = written_reg;
		count_next = count_reg;
		cycle_next = cycle_reg;
		state_next = state_reg;
		prog_next = prog_reg;
		step_next = step_reg;
		run_step_next = run_step_reg;
		total_next = total_reg;
		screen_next = screen_reg;
		saved_next = saved_reg;
		value_next = value_reg;
		out_next = out_reg;
		by_reset_next = by_reset_reg;
		refused_next = refused_reg;
		keypad_next = keypad_reg;
		mem_we = 1'b0;
		mem_wa = mem_idx(prog_reg, step_reg);
		mem_wd = edit_rec;
		timer_start = 1'b0;
		cmd = CMD_NONE;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bresp_next = bresp_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		aw_held_next = aw_held_reg | (awvalid & awready_reg);
		w_held_next = w_held_reg | (wvalid & wready_reg);
		bvalid_next = bvalid_reg & ~bready;
		if (awvalid && awready_reg)
			awaddr_next = awaddr;
		if (wvalid && wready_reg)
		begin
			wdata_next = wdata;
			wstrb_next = wstrb;
		end
		if (wr_fire)
		begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			if (awaddr_reg == A_CMD)
			begin
				if (wstrb_reg[0])
					cmd = pss_cmd_t'(wdata_reg[3:0]);
			end
			else if (awaddr_reg == A_STEP)
			begin
				if (wstrb_reg[0] && state_reg == ST_EDIT
					&& wdata_reg[6:0] <= cur_count)
					step_next = wdata_reg[6:0];
			end
			else if (awaddr_reg == A_SCREEN)
			begin
				if (wstrb_reg[0] && state_reg != ST_RUN
					&& wdata_reg[2:0] <= SCREEN_MAX)
					screen_next = wdata_reg[2:0];
			end
			else if (awaddr_reg == A_VALUE)
				value_next = 16'(merge({16'h0000, value_reg}, wdata_reg,
					wstrb_reg));
			else if (awaddr_reg != A_STATUS && awaddr_reg != A_OUTV
				&& awaddr_reg != A_OUTI && awaddr_reg != A_COUNT)
				bresp_next = RESP_SLVERR;
		end
		awready_next = ~aw_held_next;
		wready_next = ~w_held_next;

		rvalid_next = rvalid_reg & ~rready;
		if (arvalid && arready_reg)
		begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			rdata_next = 32'h00000000;
			if (araddr == A_STATUS)
				rdata_next = status;
			else if (araddr == A_OUTV)
				rdata_next = {16'h0000, out_reg.volt};
			else if (araddr == A_OUTI)
				rdata_next = {16'h0000, out_reg.curr};
			else if (araddr == A_COUNT)
				rdata_next = cnt_view;
			else if (araddr == A_STEP)
				rdata_next = {25'h0000000, step_reg};
			else if (araddr == A_SCREEN)
				rdata_next = {29'h00000000, screen_reg};
			else if (araddr == A_VALUE)
				rdata_next = {16'h0000, value_reg};
			else if (araddr != A_CMD)
				rresp_next = RESP_SLVERR;
		end
		arready_next = ~rvalid_next;

		if (cmd != CMD_NONE)
			refused_next = 1'b0;
		case (cmd)
		CMD_ENTER:
			if (state_reg != ST_RUN && value_reg[3:0] <= PROG_LAST)
			begin
				prog_next = value_reg[3:0];
				step_next = 7'h00;
				state_next = ST_EDIT;
			end
			else
				refused_next = 1'b1;
		CMD_ADD:
			if (state_reg == ST_EDIT && cur_count < 7'(MAX_STEPS)
				&& total_reg < 7'(TOTAL_STEPS))
			begin
				if (!written_reg[new_idx])
				begin
					mem_we = 1'b1;
					mem_wa = new_idx;
					mem_wd = STEP_DEFAULT;
					written_next[new_idx] = 1'b1;
				end
				count_next[prog_reg] = 7'(cur_count + 7'h01);
				total_next = 7'(total_reg + 7'h01);
				step_next = cur_count;
			end
			else
				refused_next = 1'b1;
		remove_step_cmd:
			if (state_reg == ST_EDIT && step_reg != 7'h00
				&& step_reg == 7'(cur_count - 7'h01))
			begin
				count_next[prog_reg] = step_reg;
				total_next = 7'(total_reg - 7'h01);
				step_next = 7'(step_reg - 7'h01);
			end
			else if (state_reg == ST_EDIT && step_reg == 7'h00
				&& cur_count == 7'h01)
			begin
				// stored record stays, reused when step 0 returns
				count_next[prog_reg] = 7'h00;
				total_next = 7'(total_reg - 7'h01);
			end
			else
				refused_next = 1'b1;
		CMD_SET_VOLT, CMD_SET_CURR, dwell_set_cmd, CMD_MODE_VOLT,
		CMD_MODE_CURR, CMD_POLARITY, output_on_cmd, output_off_cmd:
			if (!edit_ok || (!REVERSIBLE && cmd >= CMD_MODE_VOLT))
				refused_next = 1'b1;
			else
			begin
				mem_we = 1'b1;
				if (cmd == CMD_SET_VOLT)
					mem_wd.volt = value_reg;
				else if (cmd == CMD_SET_CURR)
					mem_wd.curr = value_reg;
				else if (cmd == dwell_set_cmd)
					mem_wd.dwell = value_reg;
				else if (cmd == CMD_MODE_VOLT || cmd == CMD_MODE_CURR)
					mem_wd.mode_curr = cmd == CMD_MODE_CURR;
				else if (cmd == CMD_POLARITY)
					mem_wd.pol_rev = ~edit_rec.pol_rev;
				else
					mem_wd.out_en = cmd == output_on_cmd;
			end
		CMD_CYCLE:
			if (state_reg == ST_EDIT && step_reg == cur_count)
				cycle_next[prog_reg] = 1'b1;
			else
				refused_next = 1'b1;
		CMD_EXECUTE:
			if ((state_reg == ST_EDIT || state_reg == ST_STOP)
				&& cur_count != 7'h00)
			begin
				saved_next = screen_reg;
				run_step_next = 7'h00;
				out_next = load_out(run_rec);
				timer_start = 1'b1;
				by_reset_next = 1'b0;
				state_next = ST_RUN;
			end
			else
				refused_next = 1'b1;
		CMD_CANCEL:
			if (state_reg == ST_RUN)
			begin
				state_next = ST_STOP;
				screen_next = saved_reg;
			end
			else if (state_reg == ST_EDIT || state_reg == ST_STOP)
			begin
				state_next = ST_IDLE;
				keypad_next = out_reg.out_en
					|| (!REVERSIBLE && by_reset_reg);
			end
			else
				refused_next = 1'b1;
		CMD_RESET:
			if (state_reg == ST_RUN)
			begin
				state_next = ST_STOP;
				screen_next = saved_reg;
				out_next.volt = 16'h0000;
				out_next.curr = 16'h0000;
				if (REVERSIBLE)
					out_next.out_en = 1'b0;
				by_reset_next = 1'b1;
			end
			else
				refused_next = 1'b1;
		default:
			;
		endcase

		if (state_reg == ST_RUN && timer_done && cmd != CMD_CANCEL
			&& cmd != CMD_RESET)
		begin
			if (last_step && !cycle_reg[prog_reg])
			begin
				state_next = ST_STOP;
				screen_next = saved_reg;
			end
			else
			begin
				run_step_next = last_step ? 7'h00 : nxt_step;
				out_next = load_out(run_rec);
				timer_start = 1'b1;
			end
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge aclk)
	begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			written_reg <= '0;
			count_reg <= '{default: 7'h00};
			cycle_reg <= '0;
			state_reg <= ST_IDLE;
			prog_reg <= 4'h0;
			step_reg <= 7'h00;
			run_step_reg <= 7'h00;
			total_reg <= 7'h00;
			screen_reg <= 3'h0;
			saved_reg <= 3'h0;
			value_reg <= 16'h0000;
			out_reg <= '0;
			by_reset_reg <= 1'b0;
			refused_reg <= 1'b0;
			keypad_reg <= 1'b0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end
		else
		begin
			written_reg <= written_next;
			count_reg <= count_next;
			cycle_reg <= cycle_next;
			state_reg <= state_next;
			prog_reg <= prog_next;
			step_reg <= step_next;
			run_step_reg <= run_step_next;
			total_reg <= total_next;
			screen_reg <= screen_next;
			saved_reg <= saved_next;
			value_reg <= value_next;
			out_reg <= out_next;
			by_reset_reg <= by_reset_next;
			refused_reg <= refused_next;
			keypad_reg <= keypad_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign setpoint = out_reg;
	assign program_mode = state_reg != ST_IDLE;
	assign run_active = state_reg == ST_RUN;
	assign keypad_idle = keypad_reg;

	// ****************************************************************
	// checks
	// ****************************************************************
	new_default_a: assert property (cmd == CMD_ADD && mem_we
		|-> mem_wd == STEP_DEFAULT && !written_reg[mem_wa])
		else $error("added step not defaulted");
	set_guard_a: assert property (mem_we && cmd != CMD_ADD
		|-> step_reg < cur_count && state_reg == ST_EDIT)
		else $error("unadded step written");
	hold_dwell_a: assert property (state_reg == ST_RUN && !timer_done
		&& cmd == CMD_NONE |=> $stable(out_reg) && state_reg == ST_RUN)
		else $error("step output moved early");
	wrap_zero_a: assert property (state_reg == ST_RUN && timer_done
		&& last_step && cycle_reg[prog_reg] && cmd == CMD_NONE
		|=> state_reg == ST_RUN && run_step_reg == 7'h00)
		else $error("cycle did not wrap");
	halt_last_a: assert property (state_reg == ST_RUN && timer_done
		&& last_step && !cycle_reg[prog_reg] && cmd == CMD_NONE
		|=> state_reg == ST_STOP ##1 state_reg == ST_STOP [*2])
		else $error("run did not halt");
	cancel_keep_a: assert property (state_reg == ST_RUN
		&& cmd == CMD_CANCEL |=> state_reg == ST_STOP && $stable(out_reg))
		else $error("cancel changed output");
	reset_zero_a: assert property (state_reg == ST_RUN && cmd == CMD_RESET
		|=> out_reg.volt == 16'h0000 && out_reg.curr == 16'h0000
		&& (!REVERSIBLE || !out_reg.out_en)) else $error("reset not zeroed");
	exec_start_a: assert property (cmd == CMD_EXECUTE
		&& state_reg == ST_STOP && cur_count != 7'h00
		|=> run_step_reg == 7'h00 && state_reg == ST_RUN)
		else $error("restart not at step 0");
	step0_keep_a: assert property (cmd == remove_step_cmd
		&& step_reg == 7'h00 && cur_count > 7'h01
		|=> $stable(total_reg) && refused_reg)
		else $error("step 0 removed early");
	screen_back_a: assert property (state_reg == ST_RUN
		##1 state_reg == ST_STOP |-> screen_reg == saved_reg)
		else $error("screen not restored");
	pool_limit_a: assert property (total_reg <= 7'(TOTAL_STEPS)
		&& cur_count <= 7'(MAX_STEPS)) else $error("step pool overrun");

endmodule

/* File: inc/pss_pkg.sv */
package pss_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 5;
	// dwell resolution is one tenth of a second
	localparam int TICK_NS       = 100_000_000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

	// ****************************************************************
	// storage sizes
	// ****************************************************************
	localparam int NUM_PROGS   = 10;
	localparam int TOTAL_STEPS = 99;
	localparam int MAX_STEPS   = 90;
	localparam int MEM_DEPTH   = NUM_PROGS * MAX_STEPS;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] A_CMD    = 8'h00;
	localparam logic [7:0] A_STEP   = 8'h04;
	localparam logic [7:0] A_SCREEN = 8'h08;
	localparam logic [7:0] A_VALUE  = 8'h0C;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_OUTV   = 8'h14;
	localparam logic [7:0] A_OUTI   = 8'h18;
	localparam logic [7:0] A_COUNT  = 8'h1C;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// step defaults and limits
	// ****************************************************************
	localparam logic [15:0] DEF_VOLT   = 16'h0000;
	localparam logic [15:0] DEF_CURR   = 16'h0000;
	localparam logic [15:0] DEF_DWELL  = 16'h0001;
	localparam logic [2:0]  SCREEN_MAX = 3'h4;
	localparam logic [3:0]  PROG_LAST  = 4'h9;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [3:0] {
		CMD_NONE, CMD_ENTER, CMD_ADD, remove_step_cmd, CMD_SET_VOLT,
		CMD_SET_CURR, dwell_set_cmd, CMD_MODE_VOLT, CMD_MODE_CURR,
		CMD_POLARITY, output_on_cmd, output_off_cmd, CMD_CYCLE,
		CMD_EXECUTE, CMD_CANCEL, CMD_RESET
	} pss_cmd_t;

	typedef enum logic [1:0] {ST_IDLE, ST_EDIT, ST_RUN, ST_STOP} pss_state_t;

	typedef struct packed {
		logic [15:0] volt;
		logic [15:0] curr;
		logic [15:0] dwell;
		logic        mode_curr;
		logic        pol_rev;
		logic        out_en;
	} pss_step_t;

	typedef struct packed {
		logic [15:0] volt;
		logic [15:0] curr;
		logic        mode_curr;
		logic        pol_rev;
		logic        out_en;
	} pss_out_t;

	typedef struct packed {
		logic [4:0] zero;
		logic [6:0] run_step;
		logic [6:0] edit_step;
		logic [3:0] program_number;
		logic [2:0] screen_index;
		logic       refused;
		logic       by_reset;
		logic       keypad_idle;
		logic       cycle;
		pss_state_t state;
	} pss_status_t;

	typedef struct packed {
		logic [16:0] zero_hi;
		logic [6:0]  total;
		logic        zero_lo;
		logic [6:0]  count;
	} pss_count_t;

	localparam pss_step_t STEP_DEFAULT = '{DEF_VOLT, DEF_CURR, DEF_DWELL,
		1'b0, 1'b0, 1'b1};

endpackage

/* File: verilog/pss_dwell_timer.sv */
`timescale 1ns/100ps
module pss_dwell_timer
	import pss_pkg::*;
#(
	parameter int TICK_P = TICK_CYCLES
)
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// control
	input  wire logic        start,
	input  wire logic [15:0] dwell,
	// result
	output logic             done
);
	localparam int PW = $clog2(TICK_P + 1);

	logic [PW-1:0] pre_reg, pre_next;
	logic [15:0]   left_reg, left_next;
	logic          busy_reg, busy_next;
	logic          done_reg, done_next;

	// ****************************************************************
	// tenth-second prescaler and countdown
	// ****************************************************************
	always_comb
	begin
		pre_next  = pre_reg;
		left_next = left_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (start)
		begin
			pre_next  = '0;
			left_next = (dwell == 16'h0000) ? 16'h0001 : dwell;
			busy_next = 1'b1;
		end
		else if (busy_reg)
		begin
			if (pre_reg == PW'(TICK_P - 1))
			begin
				pre_next  = '0;
				left_next = left_reg - 16'h0001;
				if (left_reg == 16'h0001)
				begin
					busy_next = 1'b0;
					done_next = 1'b1;
				end
			end
			else
				pre_next = pre_reg + PW'(1);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pre_reg  <= '0;
			left_reg <= 16'h0000;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			pre_reg  <= pre_next;
			left_reg <= left_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;

	dwell_min_a: assert property (@(posedge aclk) disable iff (!aresetn)
		start |=> !done_reg ##0 busy_reg) else $error("dwell ended early");

endmodule

/* File: tb/pss_panel.sv */
`timescale 1ns/100ps
module pss_panel
(
	// clock
	input  wire logic        aclk,
	// write channels
	output logic             awvalid,
	input  wire logic        awready,
	output logic [7:0]       awaddr,
	output logic             wvalid,
	input  wire logic        wready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	input  wire logic        bvalid,
	output logic             bready,
	input  wire logic [1:0]  bresp,
	// read channels
	output logic             arvalid,
	input  wire logic        arready,
	output logic [7:0]       araddr,
	input  wire logic        rvalid,
	output logic             rready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp
);
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, wstrb, araddr} = '0;
	end
	// each channel is held until its own handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				d = rdata;
				rready <= 1'b0;
				break;
			end
		end
	endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
	import pss_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        program_mode, run_active, keypad_idle;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_val;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	pss_out_t    setpoint;
	int          failures = 0;
	int          num_checks = 0;
	int          cycles = 0;

	always #2.5 aclk = ~aclk;

	pss_sequencer #(.TICK_CYCLES_P(4), .REVERSIBLE(1'b1)) u_dut (.aclk,
		.aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.rvalid, .rready, .rdata, .rresp, .setpoint, .program_mode,
		.run_active, .keypad_idle);
	pss_panel u_panel (.aclk, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp);

	// ****
	// helpers
	// ****
	task automatic report_and_stop;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input pss_cmd_t c, input logic [15:0] v);
		u_panel.wr(A_VALUE, {16'h0000, v}, resp);
		u_panel.wr(A_CMD, {28'h0000000, c}, resp);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		u_panel.rd(a, rd_val);
		check(rd_val & m, e);
	endtask
	task automatic wait_volt(input logic [15:0] v, input int n);
		for (int k = 0; k < n && setpoint.volt !== v; k++)
			@(posedge aclk);
		check({16'h0000, setpoint.volt}, {16'h0000, v});
	endtask

	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			failures++;
			report_and_stop();
		end
	end

	// ****
	// tests
	// ****
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		cmd(CMD_ENTER, 16'h0002);
		cmd(CMD_SET_VOLT, 16'h0005);
		rchk(A_STATUS, 32'h20, 32'h20);
		cmd(CMD_CANCEL, 16'h0000);
		check({program_mode, keypad_idle}, 2'b00);
		cmd(CMD_ENTER, 16'h0002);
		cmd(CMD_ADD, 16'h0000);
		cmd(CMD_ADD, 16'h0000);
		rchk(A_COUNT, 32'h7F7F, 32'h0202);
		u_panel.wr(A_STEP, 32'h0, resp);
		cmd(CMD_SET_VOLT, 16'h0100);
		cmd(remove_step_cmd, 16'h0000);
		rchk(A_COUNT, 32'h7F, 32'h02);
		u_panel.wr(A_STEP, 32'h1, resp);
		cmd(CMD_SET_VOLT, 16'h0200);
		cmd(dwell_set_cmd, 16'h0002);
		cmd(CMD_POLARITY, 16'h0000);
		cmd(remove_step_cmd, 16'h0000);
		rchk(A_COUNT, 32'h7F, 32'h01);
		cmd(CMD_ADD, 16'h0000);
		$display("test edit done");
		cmd(CMD_EXECUTE, 16'h0000);
		wait_volt(16'h0100, 3);
		check(setpoint[2:0], 3'b001);
		wait_volt(16'h0200, 20);
		check(setpoint[2:0], 3'b011);
		for (int k = 0; k < 40 && run_active !== 1'b0; k++)
			@(posedge aclk);
		rchk(A_STATUS, 32'h3, 32'h3);
		$display("test run done");
		// a stopped program must be re-entered before it can be edited
		cmd(CMD_ENTER, 16'h0002);
		u_panel.wr(A_STEP, 32'h2, resp);
		cmd(CMD_CYCLE, 16'h0000);
		cmd(CMD_EXECUTE, 16'h0000);
		wait_volt(16'h0200, 20);
		wait_volt(16'h0100, 20);
		cmd(CMD_RESET, 16'h0000);
		check({setpoint.volt, setpoint.curr}, 32'h0);
		check(setpoint.out_en, 1'b0);
		cmd(CMD_EXECUTE, 16'h0000);
		wait_volt(16'h0100, 2);
		wait_volt(16'h0200, 20);
		cmd(CMD_CANCEL, 16'h0000);
		repeat (20) @(posedge aclk);
		wait_volt(16'h0200, 0);
		cmd(CMD_CANCEL, 16'h0000);
		check({program_mode, keypad_idle}, 2'b01);
		$display("test stop done");
		u_panel.wr(8'h20, 32'h0, resp);
		check(resp, RESP_SLVERR);
		u_panel.rd(8'h20, rd_val);
		check(rd_val, 32'h00000000);
		check(rresp, RESP_SLVERR);
		$display("test bus done");
		report_and_stop();
	end
endmodule
